// ===== inc/cio_params.svh
/*
  Constants of the configurable I/O ports: register offsets, port indices,
  port capability masks and reset values.
  Assumes inclusion by both ends; holds definitions only.
*/
`ifndef CIO_PARAMS_SVH
`define CIO_PARAMS_SVH

// Port indices
`define CIO_PORT_A      3'h0
`define CIO_PORT_B      3'h1
`define CIO_PORT_C      3'h2
`define CIO_PORT_D      3'h3
`define CIO_PORT_E      3'h4
`define CIO_PORT_F      3'h5
`define CIO_PORT_G      3'h6
`define CIO_NUM_PORTS   7

// Offset = {kind[4:0], port[2:0]} within the I/O register space
`define CIO_KIND_DIN    5'h00
`define CIO_KIND_DOUT   5'h01
`define CIO_KIND_MODE   5'h02
`define CIO_KIND_DIR    5'h03
`define CIO_KIND_DRV    5'h04

// Capability masks, one bit per port, bit 0 = port A
`define CIO_CTL_PORTS   7'h70
`define CIO_OD_PORTS    7'h5b
`define CIO_LA_OUT_PORTS 7'h07
`define CIO_AIN_PORTS   7'h2f

// Port D has four pins
`define CIO_PORT_D_MASK 8'h0f
`define CIO_FULL_MASK   8'hff
`define CIO_REG_RESET   8'h00
`define CIO_UNMAPPED    8'h00

`endif

// ===== inc/cio_pkg.sv
/*
  Types shared by both ends of the configurable I/O ports.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cio_pkg;

  typedef logic [7:0] cio_byte_type;

  typedef logic [6:0][7:0] cio_ports_type;

  typedef enum logic [1:0] {
    CIO_H_IDLE,
    CIO_H_LATCH,
    CIO_H_STROBE,
    CIO_H_WAIT
  } cio_host_state_type;

endpackage

// ===== inc/cio_if.sv
/*
  Host bus between the microcontroller end and the I/O port device.
  Assumes both ends run on the same mclk; all signals active high.
*/
`timescale 1ns/1ps

interface cio_if;
  logic                  ale;
  logic                  io_sel;
  logic                  rd;
  logic                  wr;
  cio_pkg::cio_byte_type addr;
  cio_pkg::cio_byte_type wdata;
  cio_pkg::cio_byte_type rdata;
  logic                  rvalid;

  modport host (
    output ale,
    output io_sel,
    output rd,
    output wr,
    output addr,
    output wdata,
    input  rdata,
    input  rvalid
  );

  modport dev (
    input  ale,
    input  io_sel,
    input  rd,
    input  wr,
    input  addr,
    input  wdata,
    output rdata,
    output rvalid
  );
endinterface

// ===== design/cio_port_dev.sv
/*
  Device end: seven configurable I/O ports (A..G), their configuration and
  data registers, address latch, pin multiplexer and drivers.
  Assumes a host end on the same mclk over cio_if, and asynchronous pins.
*/
`timescale 1ns/1ps
`include "cio_params.svh"

module cio_port_dev (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  cio_if.dev                         bus,
  input  wire cio_pkg::cio_ports_type pin_in,
  output cio_pkg::cio_ports_type     pin_out_q,
  output cio_pkg::cio_ports_type     pin_oe_n_q,
  output cio_pkg::cio_byte_type      slew_fast_q,
  input  wire cio_pkg::cio_ports_type cfg_la_pin,
  input  wire cio_pkg::cio_ports_type cfg_addr_in,
  input  wire logic                  cfg_nonmux,
  input  wire cio_pkg::cio_ports_type la_oe,
  input  wire cio_pkg::cio_ports_type la_out,
  output cio_pkg::cio_ports_type     la_in_q,
  output cio_pkg::cio_ports_type     addr_hi_q
);

  localparam logic [6:0] CTL_PORTS = `CIO_CTL_PORTS;
  localparam logic [6:0] OD_PORTS  = `CIO_OD_PORTS;
  localparam logic [6:0] LA_PORTS  = `CIO_LA_OUT_PORTS;
  localparam logic [6:0] AIN_PORTS = `CIO_AIN_PORTS;

  cio_pkg::cio_ports_type dout_q,  dout_d;
  cio_pkg::cio_ports_type dir_q,   dir_d;
  cio_pkg::cio_ports_type mode_q,  mode_d;
  cio_pkg::cio_ports_type drv_q,   drv_d;
  cio_pkg::cio_ports_type s1_q,    s2_q,    s3_q;
  cio_pkg::cio_ports_type sync_q,  sync_d;
  cio_pkg::cio_ports_type ahi_d;
  cio_pkg::cio_ports_type pout_d,  oe_n_d;
  cio_pkg::cio_byte_type  alat_q,  alat_d;
  cio_pkg::cio_byte_type  rdata_q, rdata_d;
  cio_pkg::cio_byte_type  slew_d;
  logic                   rvalid_q;
  logic                   rvalid_d;

  assign bus.rdata  = rdata_q;
  assign bus.rvalid = rvalid_q;

  // Port D keeps only its four pins
  function automatic cio_pkg::cio_byte_type port_mask(input logic [2:0] p);
    port_mask = (p == `CIO_PORT_D) ? `CIO_PORT_D_MASK : `CIO_FULL_MASK;
  endfunction

  always_comb begin
    logic [2:0] sel;
    logic [4:0] kind;
    logic       hit;
    logic       dport;
    logic       amode;
    logic       val;
    logic       en;
    sel     = bus.addr[2:0];
    kind    = bus.addr[7:3];
    hit     = bus.io_sel && (sel != 3'h7);
    dout_d  = dout_q;
    dir_d   = dir_q;
    mode_d  = mode_q;
    drv_d   = drv_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    dport   = 1'b0;
    amode   = 1'b0;
    val     = 1'b0;
    en      = 1'b0;
    // Multiplexed bus: low address held from the strobe onward
    alat_d  = bus.ale ? bus.addr : alat_q;
    // Pin level accepted once two later stages agree
    sync_d  = (s2_q & s3_q) | (sync_q & (s2_q ^ s3_q));

    // Register writes, per-pin bit alignment
    if (hit && bus.wr) begin
      case (kind)
        `CIO_KIND_DOUT: dout_d[sel] = bus.wdata & port_mask(sel);
        `CIO_KIND_MODE: mode_d[sel] = CTL_PORTS[sel] ? bus.wdata : `CIO_REG_RESET;
        `CIO_KIND_DIR:  dir_d[sel]  = bus.wdata & port_mask(sel);
        `CIO_KIND_DRV:  drv_d[sel]  = bus.wdata & port_mask(sel);
        default: ;
      endcase
    end

    // Register reads
    if (bus.io_sel && bus.rd) begin
      rvalid_d = 1'b1;
      if (!hit) begin
        rdata_d = `CIO_UNMAPPED;
      end else begin
        case (kind)
          `CIO_KIND_DIN:  rdata_d = sync_q[sel];
          `CIO_KIND_DOUT: rdata_d = dout_q[sel];
          `CIO_KIND_MODE: rdata_d = mode_q[sel];
          `CIO_KIND_DIR:  rdata_d = dir_q[sel];
          `CIO_KIND_DRV:  rdata_d = drv_q[sel];
          default:        rdata_d = `CIO_UNMAPPED;
        endcase
      end
    end

    // High address inputs caught by the address strobe
    for (int p = 0; p < `CIO_NUM_PORTS; p++) begin
      ahi_d[p] = bus.ale ? (sync_q[p] & cfg_addr_in[p] & {8{AIN_PORTS[p]}})
                         : addr_hi_q[p];
    end

    // Pin multiplexer and drivers, from registered state and the unregistered la_oe, la_out and configuration inputs
    for (int p = 0; p < `CIO_NUM_PORTS; p++) begin
      for (int b = 0; b < 8; b++) begin
        dport = (p == int'(`CIO_PORT_F)) && cfg_nonmux;
        amode = CTL_PORTS[p] && mode_q[p][b] && (dir_q[p][b] || la_oe[p][b])
                && (!cfg_nonmux || p == int'(`CIO_PORT_G));
        if (dport) begin
          val = rdata_q[b];
          en  = rvalid_q;
        end else if (AIN_PORTS[p] && cfg_addr_in[p][b]) begin
          val = 1'b0;
          en  = 1'b0;
        end else if (LA_PORTS[p] && cfg_la_pin[p][b]) begin
          val = la_out[p][b];
          en  = la_oe[p][b];
        end else if (amode) begin
          val = alat_q[b];
          en  = 1'b1;
        end else begin
          val = dout_q[p][b];
          en  = dir_q[p][b] || la_oe[p][b];
        end
        if (p == int'(`CIO_PORT_D) && b > 3) begin
          en = 1'b0;
        end
        if (OD_PORTS[p] && drv_q[p][b] && !dport) begin
          pout_d[p][b] = 1'b0;
          oe_n_d[p][b] = !(en && !val);
        end else begin
          pout_d[p][b] = val;
          oe_n_d[p][b] = !en;
        end
      end
    end
    slew_d = drv_q[`CIO_PORT_C];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dout_q      <= '0;
      dir_q       <= '0;
      mode_q      <= '0;
      drv_q       <= '0;
      s1_q        <= '0;
      s2_q        <= '0;
      s3_q        <= '0;
      sync_q      <= '0;
      alat_q      <= `CIO_REG_RESET;
      rdata_q     <= `CIO_REG_RESET;
      rvalid_q    <= 1'b0;
      addr_hi_q   <= '0;
      la_in_q     <= '0;
      pin_out_q   <= '0;
      pin_oe_n_q  <= '1;
      slew_fast_q <= `CIO_REG_RESET;
    end else begin
      dout_q      <= dout_d;
      dir_q       <= dir_d;
      mode_q      <= mode_d;
      drv_q       <= drv_d;
      s1_q        <= pin_in;
      s2_q        <= s1_q;
      s3_q        <= s2_q;
      sync_q      <= sync_d;
      alat_q      <= alat_d;
      rdata_q     <= rdata_d;
      rvalid_q    <= rvalid_d;
      addr_hi_q   <= ahi_d;
      la_in_q     <= sync_q;
      pin_out_q   <= pout_d;
      pin_oe_n_q  <= oe_n_d;
      slew_fast_q <= slew_d;
    end
  end

endmodule // cio_port_dev

// ===== design/cio_host_end.sv
/*
  Host end: turns single register commands into bus cycles on cio_if
  (address strobe, then read or write strobe) and returns read data.
  Assumes the device end on the same mclk.
*/
`timescale 1ns/1ps
`include "cio_params.svh"

module cio_host_end (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  cio_if.host                         bus,
  input  wire logic                   cmd_valid,
  input  wire logic                   cmd_write,
  input  wire cio_pkg::cio_byte_type  cmd_addr,
  input  wire cio_pkg::cio_byte_type  cmd_wdata,
  input  wire cio_pkg::cio_ports_type la_in_mask,
  output logic                        cmd_ready_q,
  output logic                        rsp_valid_q,
  output cio_pkg::cio_byte_type       rsp_data_q
);

  cio_pkg::cio_host_state_type state_q, state_d;
  logic                  ale_q, ale_d;
  logic                  io_sel_q, io_sel_d;
  logic                  rd_q, rd_d;
  logic                  wr_q, wr_d;
  logic                  write_q, write_d;
  logic                  ready_d;
  logic                  rsp_valid_d;
  cio_pkg::cio_byte_type addr_q, addr_d;
  cio_pkg::cio_byte_type wdata_q, wdata_d;
  cio_pkg::cio_byte_type rsp_data_d;

  assign bus.ale    = ale_q;
  assign bus.io_sel = io_sel_q;
  assign bus.rd     = rd_q;
  assign bus.wr     = wr_q;
  assign bus.addr   = addr_q;
  assign bus.wdata  = wdata_q;

  always_comb begin
    state_d     = state_q;
    ale_d       = 1'b0;
    io_sel_d    = 1'b0;
    rd_d        = 1'b0;
    wr_d        = 1'b0;
    write_d     = write_q;
    addr_d      = addr_q;
    wdata_d     = wdata_q;
    rsp_valid_d = 1'b0;
    rsp_data_d  = rsp_data_q;
    case (state_q)
      cio_pkg::CIO_H_IDLE: begin
        if (cmd_valid) begin
          ale_d   = 1'b1;
          addr_d  = cmd_addr;
          write_d = cmd_write;
          wdata_d = cmd_wdata;
          if (cmd_addr[7:3] == `CIO_KIND_DIR && cmd_addr[2:0] != 3'h7) begin
            wdata_d = cmd_wdata & ~la_in_mask[cmd_addr[2:0]];
          end
          state_d = cio_pkg::CIO_H_LATCH;
        end
      end
      cio_pkg::CIO_H_LATCH: begin
        io_sel_d = 1'b1;
        rd_d     = !write_q;
        wr_d     = write_q;
        state_d  = cio_pkg::CIO_H_STROBE;
      end
      cio_pkg::CIO_H_STROBE: begin
        if (write_q) begin
          rsp_valid_d = 1'b1;
          state_d     = cio_pkg::CIO_H_IDLE;
        end else begin
          state_d = cio_pkg::CIO_H_WAIT;
        end
      end
      cio_pkg::CIO_H_WAIT: begin
        if (bus.rvalid) begin
          rsp_valid_d = 1'b1;
          rsp_data_d  = bus.rdata;
          state_d     = cio_pkg::CIO_H_IDLE;
        end
      end
      default: state_d = cio_pkg::CIO_H_IDLE;
    endcase
    ready_d = (state_d == cio_pkg::CIO_H_IDLE);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q     <= cio_pkg::CIO_H_IDLE;
      ale_q       <= 1'b0;
      io_sel_q    <= 1'b0;
      rd_q        <= 1'b0;
      wr_q        <= 1'b0;
      write_q     <= 1'b0;
      addr_q      <= `CIO_REG_RESET;
      wdata_q     <= `CIO_REG_RESET;
      cmd_ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= `CIO_REG_RESET;
    end else begin
      state_q     <= state_d;
      ale_q       <= ale_d;
      io_sel_q    <= io_sel_d;
      rd_q        <= rd_d;
      wr_q        <= wr_d;
      write_q     <= write_d;
      addr_q      <= addr_d;
      wdata_q     <= wdata_d;
      cmd_ready_q <= ready_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q  <= rsp_data_d;
    end
  end

endmodule // cio_host_end

// ===== verification/cio_sva.sv
/*
  Checker for the host bus between the two ends of the I/O ports.
  Assumes instantiation beside cio_if, with reset active high.
*/
`timescale 1ns/1ps
`include "cio_params.svh"

module cio_sva (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic                  ale,
  input wire logic                  io_sel,
  input wire logic                  rd,
  input wire logic                  wr,
  input wire cio_pkg::cio_byte_type addr,
  input wire cio_pkg::cio_byte_type wdata,
  input wire cio_pkg::cio_byte_type rdata,
  input wire logic                  rvalid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  cio_pkg::cio_byte_type wa_q;
  cio_pkg::cio_byte_type wd_q;

  // Last written address and data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wa_q <= 8'hff;
      wd_q <= 8'h00;
    end else if (io_sel && wr) begin
      wa_q <= addr;
      wd_q <= wdata;
    end
  end

  rd_answer_a: assert property (io_sel && rd |=> rvalid)
    else $error("read strobe without answer");
  answer_cause_a: assert property (rvalid |-> $past(io_sel && rd))
    else $error("answer without read strobe");
  strobe_order_a: assert property (ale |=> io_sel && (rd ^ wr))
    else $error("strobe does not follow address strobe");
  unmapped_read_a: assert property (io_sel && rd && addr[2:0] == 3'h7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  mode_abcd_a: assert property (io_sel && rd && addr[7:3] == `CIO_KIND_MODE &&
    addr[2:0] < 3'h4 |=> rdata == `CIO_REG_RESET) else $error("mode of port A to D not zero");
  port_d_a: assert property (io_sel && rd && addr[2:0] == `CIO_PORT_D &&
    addr[7:3] inside {5'h01, 5'h03, 5'h04} |=> rdata[7:4] == 4'h0)
    else $error("port D upper bits set");
  dir_readback_a: assert property (io_sel && rd && addr == wa_q &&
    addr[7:3] == `CIO_KIND_DIR && addr[2:0] != `CIO_PORT_D && addr[2:0] != 3'h7 |=>
    rvalid && rdata == wd_q) else $error("direction read back differs");
  rdata_hold_a: assert property (rvalid ##1 !rvalid |-> $stable(rdata))
    else $error("read data changed after answer");
endmodule // cio_sva

// ===== verification/config_io_port_modes_tb.sv
/*
  Bench: host end and device end joined by cio_if, driven by register commands.
  Assumes the checker cio_sva beside the interface.
*/
`timescale 1ns/1ps
`include "cio_params.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module config_io_port_modes_tb;
  logic                   mclk, rst, cmd_valid, cmd_write, cmd_ready_q, rsp_valid_q;
  cio_pkg::cio_byte_type  cmd_addr, cmd_wdata, rsp_data_q, slew_fast_q;
  cio_pkg::cio_ports_type pin_in, la_oe, pin_out_q, pin_oe_n_q, la_in_q, addr_hi_q;
  cio_pkg::cio_ports_type cfg_la_pin, cfg_addr_in, la_out, la_in_mask;
  logic                   cfg_nonmux;
  int                     errors = 0;
  int                     checks_done = 0;

  cio_if bus ();
  cio_host_end cio_host_end_i (.mclk(mclk), .rst(rst), .bus(bus.host), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .la_in_mask(la_in_mask),
    .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q));
  cio_port_dev cio_port_dev_i (.mclk(mclk), .rst(rst), .bus(bus.dev), .pin_in(pin_in),
    .pin_out_q(pin_out_q), .pin_oe_n_q(pin_oe_n_q), .slew_fast_q(slew_fast_q),
    .cfg_la_pin(cfg_la_pin), .cfg_addr_in(cfg_addr_in), .cfg_nonmux(cfg_nonmux), .la_oe(la_oe),
    .la_out(la_out), .la_in_q(la_in_q), .addr_hi_q(addr_hi_q));
  cio_sva cio_sva_i (.mclk(mclk), .rst(rst), .ale(bus.ale), .io_sel(bus.io_sel), .rd(bus.rd),
    .wr(bus.wr), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic final_report;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic cio_pkg::cio_byte_type ad(input int k, input int p);
    return {k[4:0], p[2:0]};
  endfunction

  task automatic xfer(input logic w, input cio_pkg::cio_byte_type a, input cio_pkg::cio_byte_type d);
    int n;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr  <= a;
    cmd_wdata <= d;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    @(negedge mclk);
    `CHK("busy", 1'b0, cmd_ready_q)
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (rsp_valid_q !== 1'b1 && n < 20);
    `CHK("answer", 1'b1, rsp_valid_q)
    `CHK("ready", 1'b1, cmd_ready_q)
  endtask

  task automatic rd_chk(input cio_pkg::cio_byte_type a, input cio_pkg::cio_byte_type ex);
    xfer(1'b0, a, 8'h00);
    `CHK($sformatf("read %h", a), ex, rsp_data_q)
  endtask

  task automatic pins(input int p, input cio_pkg::cio_byte_type o, input cio_pkg::cio_byte_type oe);
    @(negedge mclk);
    `CHK("pin out", o, pin_out_q[p])
    `CHK("pin oe_n", oe, pin_oe_n_q[p])
  endtask

  initial begin
    rst = 1'b1; cmd_valid = 1'b0; cmd_write = 1'b0; cmd_addr = 8'h00; cmd_wdata = 8'h00;
    pin_in = 56'h0; la_oe = 56'h0;
    cfg_nonmux  = 1'b0;
    cfg_la_pin  = 56'h00_00_00_00_f0_00_00;
    la_out      = 56'h00_00_00_00_a0_00_00;
    cfg_addr_in = 56'h00_00_00_0a_00_00_00;
    la_in_mask  = 56'h00_00_00_08_00_00_00;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int p = 0; p < 7; p++) begin
      for (int k = 2; k < 5; k++) rd_chk(ad(k, p), 8'h00);
      `CHK("oe_n reset", 8'hff, pin_oe_n_q[p])
    end
    for (int p = 0; p < 8; p++) begin
      xfer(1'b1, ad(3, p), 8'h5a);
      rd_chk(ad(3, p), p == 3 ? 8'h02 : (p == 7 ? 8'h00 : 8'h5a));
      xfer(1'b1, ad(2, p), 8'h3c);
      rd_chk(ad(2, p), (p > 3 && p < 7) ? 8'h3c : 8'h00);
      if (p != 5) xfer(1'b1, ad(4, p), 8'ha5);
      if (p != 5) rd_chk(ad(4, p), p == 3 ? 8'h05 : (p == 7 ? 8'h00 : 8'ha5));
    end
    `CHK("addr in oe_n", 8'hff, pin_oe_n_q[3])
    xfer(1'b1, ad(4, 0), 8'h00);
    xfer(1'b1, ad(3, 0), 8'hff);
    xfer(1'b1, ad(1, 0), 8'ha5);
    pins(0, 8'ha5, 8'h00);
    xfer(1'b1, ad(4, 0), 8'h0f);
    pins(0, 8'ha0, 8'h05);
    rd_chk(ad(1, 0), 8'ha5);
    xfer(1'b1, ad(2, 5), 8'h00);
    xfer(1'b1, ad(3, 5), 8'hff);
    xfer(1'b1, ad(4, 5), 8'hff);
    xfer(1'b1, ad(1, 5), 8'h3c);
    pins(5, 8'h3c, 8'h00);
    xfer(1'b1, ad(4, 2), 8'h81);
    @(negedge mclk);
    `CHK("slew", 8'h81, slew_fast_q)
    xfer(1'b1, ad(3, 1), 8'h00);
    @(posedge mclk);
    pin_in[1] <= 8'h69;
    pin_in[3] <= 8'hff;
    repeat (6) @(posedge mclk);
    rd_chk(ad(0, 1), 8'h69);
    `CHK("input oe_n", 8'hff, pin_oe_n_q[1])
    `CHK("logic in", 8'h69, la_in_q[1])
    `CHK("addr hi", 8'h0a, addr_hi_q[3])
    xfer(1'b1, ad(4, 4), 8'h00);
    xfer(1'b1, ad(3, 4), 8'hff);
    xfer(1'b1, ad(2, 4), 8'hff);
    pins(4, 8'h14, 8'h00);
    xfer(1'b1, ad(3, 0), 8'h00);
    xfer(1'b1, ad(3, 4), 8'h00);
    @(negedge mclk);
    `CHK("addr out off", 8'hff, pin_oe_n_q[4])
    @(posedge mclk);
    la_oe[4] <= 8'hff;
    la_oe[0] <= 8'hff;
    la_oe[2] <= 8'hf0;
    @(negedge mclk);
    pins(4, 8'h1c, 8'h00);
    pins(0, 8'ha0, 8'h05);
    pins(2, 8'ha0, 8'h05);
    // Second reset, non-multiplexed host
    @(posedge mclk);
    rst        <= 1'b1;
    cfg_nonmux <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK("oe_n reset", 8'hff, pin_oe_n_q[0])
    rd_chk(ad(3, 0), 8'h00);
    xfer(1'b1, ad(3, 5), 8'hff);
    xfer(1'b1, ad(1, 5), 8'h3c);
    xfer(1'b1, ad(3, 6), 8'hff);
    xfer(1'b1, ad(2, 6), 8'hff);
    xfer(1'b1, ad(3, 4), 8'hff);
    xfer(1'b1, ad(2, 4), 8'hff);
    pins(6, 8'h14, 8'h00);
    pins(4, 8'h00, 8'h00);
    rd_chk(ad(2, 6), 8'hff);
    `CHK("data port", 8'hff, pin_out_q[5])
    `CHK("data port oe_n", 8'h00, pin_oe_n_q[5])
    @(negedge mclk);
    `CHK("data port idle", 8'hff, pin_oe_n_q[5])
    final_report;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    final_report;
  end
endmodule // config_io_port_modes_tb
